/* design/urb_pkg.sv */
// Purpose: constants and carriers for the serial port register banking block
// Assumes: 8-bit host data, 3-bit offset, one access per strobe
// Notes: offsets are the 3-bit window addresses
package urb_pkg;
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IEN = 3'h1;
    localparam logic [2:0] OFS_FIFO = 3'h2;
    localparam logic [2:0] OFS_LINE = 3'h3;
    localparam logic [2:0] OFS_MODEM = 3'h4;
    localparam logic [2:0] OFS_LSTAT = 3'h5;
    localparam logic [2:0] OFS_MSTAT = 3'h6;
    localparam logic [2:0] OFS_SCRATCH = 3'h7;
    localparam logic [7:0] BANK_PATTERN = 8'hbf;
    localparam int LATCH_BIT = 7;
    localparam int EXTRA_STATUS_BIT = 7;
    localparam int EXTRA_INDEX_BIT = 6;
    localparam logic [7:0] STATUS_WR_MASK = 8'h03;
    localparam logic [7:0] LINE_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;

    // msb first, so a plain cast of line format bits 6:0 lands each field
    typedef struct packed {
        logic txBreak;
        logic parityForce;
        logic parityOdd;
        logic parityEnable;
        logic stopBits;
        logic [1:0] dataLength;
    } urb_frame_t;

    typedef struct packed {
        logic [2:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } urb_access_t;
endpackage

/* design/urb_reg8.sv */
// Purpose: one host-writable byte register with masked write
// Assumes: synchronous active-low reset
// Notes: used for each plain stored register
`timescale 1ns/1ps
`default_nettype none
module urb_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff
) (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // sync reset
    input wire logic wrEn, // write strobe
    input wire logic [7:0] wdata, // write data
    input wire logic [7:0] hwVal, // value for non-writable bits
    output logic [7:0] value // stored value
);
    logic [7:0] value_q;
    logic [7:0] value_d;

    always_comb begin
        value_d = (value_q & WR_MASK) | (hwVal & ~WR_MASK);
        if (wrEn) begin
            value_d = (wdata & WR_MASK) | (hwVal & ~WR_MASK);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            value_q <= RESET_VAL;
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;
endmodule
`default_nettype wire

/* design/urb_bank_top.sv */
// Purpose: host register window decode and bank selection for one serial port
// Assumes: host strobes are synchronous to sys_clk, one cycle each
// Notes: read data registered, valid one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module urb_bank_top (
    input wire logic sys_clk, // 20 MHz clock
    input wire logic rst_n, // sync reset, active low
    input wire urb_pkg::urb_access_t hostAcc, // host address, strobes, data
    input wire logic [7:0] rxHolding, // receive holding data
    input wire logic [7:0] intSource, // interrupt source value
    input wire logic [7:0] lineStatus, // line status value
    input wire logic [7:0] modemStatus, // modem status value
    input wire logic [7:0] rxFillCount, // receive fifo level
    input wire logic [7:0] txFillCount, // transmit fifo level
    input wire logic [7:0] statusHw, // read-only extended status bits
    input wire logic [7:0] extraControl, // extra control register value
    input wire logic [7:0] idxRdata, // selected indexed register data
    output logic [7:0] rdata, // read data
    output logic rvalid, // read data valid pulse
    output logic txWrite, // transmit holding load pulse
    output logic rxRead, // receive holding pop pulse
    output logic fifoCtlWrite, // fifo control write pulse
    output logic srcRead, // interrupt source read pulse
    output logic idxWrite, // indexed window write pulse
    output logic idxRead, // indexed window read pulse
    output logic [7:0] busData, // data for write pulses
    output logic [15:0] baudDivisor, // divisor latch
    output urb_pkg::urb_frame_t frame, // framing shared by tx and rx
    output logic [7:0] intEnable, // interrupt enable
    output logic [7:0] modemControl, // modem control
    output logic [7:0] scratchPad, // scratch pad
    output logic [7:0] enhFeatures, // enhanced features
    output logic [7:0] resumeCharA, // resume char a
    output logic [7:0] resumeCharB, // resume char b
    output logic [7:0] pauseCharA, // pause char a
    output logic [7:0] pauseCharB, // pause char b
    output logic [7:0] extStatus // extended status
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] line_q, line_d;
    logic bank_q, bank_d;
    logic wr, rd;
    logic latchOpen, statusBank, idxEnable;
    logic [2:0] a;

    assign wr = hostAcc.wr;
    assign rd = hostAcc.rd;
    assign a = hostAcc.addr;
    assign latchOpen = line_q[urb_pkg::LATCH_BIT];
    assign statusBank = extraControl[urb_pkg::EXTRA_STATUS_BIT];
    assign idxEnable = extraControl[urb_pkg::EXTRA_INDEX_BIT];

    // bank flag follows only the last line format write
    always_comb begin
        line_d = line_q;
        bank_d = bank_q;
        if (wr && a == urb_pkg::OFS_LINE && !bank_q) begin
            if (hostAcc.wdata == urb_pkg::BANK_PATTERN) begin
                line_d = {1'b1, line_q[6:0]};
                bank_d = 1'b1;
            end else begin
                line_d = hostAcc.wdata;
                bank_d = 1'b0;
            end
        end else if (wr && a == urb_pkg::OFS_LINE) begin
            // a line format write exits the bank unless it is the pattern again
            bank_d = (hostAcc.wdata == urb_pkg::BANK_PATTERN);
            line_d = bank_d ? {1'b1, line_q[6:0]} : hostAcc.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            line_q <= urb_pkg::LINE_RESET;
            bank_q <= 1'b0;
        end else begin
            line_q <= line_d;
            bank_q <= bank_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write decode per register
    logic wDll, wDlm, wIer, wMcr, wSpr, wEfr, wXa, wXb, wPa, wPb, wAsr;
    logic normal;
    assign normal = !bank_q;
    assign wDll = wr && a == urb_pkg::OFS_DATA && latchOpen && normal;
    assign wDlm = wr && a == urb_pkg::OFS_IEN && latchOpen && normal;
    assign wAsr = wr && a == urb_pkg::OFS_IEN && statusBank && !latchOpen;
    assign wIer = wr && a == urb_pkg::OFS_IEN && !latchOpen && !statusBank;
    assign wEfr = wr && a == urb_pkg::OFS_FIFO && bank_q;
    assign wMcr = wr && a == urb_pkg::OFS_MODEM && normal;
    assign wXa = wr && a == urb_pkg::OFS_MODEM && bank_q;
    assign wXb = wr && a == urb_pkg::OFS_LSTAT && bank_q;
    assign wPa = wr && a == urb_pkg::OFS_MSTAT && bank_q;
    assign wPb = wr && a == urb_pkg::OFS_SCRATCH && bank_q;
    assign wSpr = wr && a == urb_pkg::OFS_SCRATCH && normal;

    logic [7:0] dll, baud_divisor_high;
    urb_reg8 uDll (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wDll), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(dll));
    urb_reg8 uDlm (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wDlm), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(baud_divisor_high));
    urb_reg8 uIer (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wIer), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(intEnable));
    urb_reg8 uMcr (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wMcr), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(modemControl));
    urb_reg8 uSpr (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wSpr), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(scratchPad));
    urb_reg8 uEfr (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wEfr), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(enhFeatures));
    urb_reg8 uXa (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wXa), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(resumeCharA));
    urb_reg8 uXb (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wXb), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(resumeCharB));
    urb_reg8 uPa (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wPa), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(pauseCharA));
    urb_reg8 uPb (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wPb), .wdata(hostAcc.wdata),
        .hwVal(8'h00), .value(pauseCharB));
    // status bits above 1 track hardware, host owns bits 1:0
    urb_reg8 #(.WR_MASK(urb_pkg::STATUS_WR_MASK)) uAsr (.sys_clk(sys_clk), .rst_n(rst_n),
        .wrEn(wAsr), .wdata(hostAcc.wdata), .hwVal(statusHw), .value(extStatus));

    assign baudDivisor = {baud_divisor_high, dll};
    assign frame = urb_pkg::urb_frame_t'(line_q[6:0]);

    ////////////////////////////////////////////////////////////////////////////
    // read mux and side-effect pulses
    logic [7:0] rdata_q, rdata_d, bus_q, bus_d;
    logic rvalid_q, tx_q, rx_q, fc_q, sr_q, iw_q, ir_q;
    logic tx_d, rx_d, fc_d, sr_d, iw_d, ir_d;

    always_comb begin
        rdata_d = 8'h00;
        rx_d = 1'b0;
        sr_d = 1'b0;
        ir_d = 1'b0;
        tx_d = wr && a == urb_pkg::OFS_DATA && !latchOpen && normal;
        fc_d = wr && a == urb_pkg::OFS_FIFO && normal;
        iw_d = wr && a == urb_pkg::OFS_LSTAT && normal;
        bus_d = wr ? hostAcc.wdata : bus_q;
        if (rd) begin
            unique case (a)
                urb_pkg::OFS_DATA: begin
                    if (latchOpen) begin
                        rdata_d = dll;
                    end else begin
                        rdata_d = rxHolding;
                        rx_d = 1'b1;
                    end
                end
                urb_pkg::OFS_IEN: begin
                    if (statusBank && !latchOpen) begin
                        rdata_d = extStatus;
                    end else if (latchOpen) begin
                        rdata_d = baud_divisor_high;
                    end else begin
                        rdata_d = intEnable;
                    end
                end
                urb_pkg::OFS_FIFO: begin
                    if (bank_q) begin
                        rdata_d = enhFeatures;
                    end else begin
                        rdata_d = intSource;
                        sr_d = 1'b1;
                    end
                end
                urb_pkg::OFS_LINE: begin
                    rdata_d = statusBank ? rxFillCount : line_q;
                end
                urb_pkg::OFS_MODEM: begin
                    if (bank_q) begin
                        rdata_d = resumeCharA;
                    end else begin
                        rdata_d = statusBank ? txFillCount : modemControl;
                    end
                end
                urb_pkg::OFS_LSTAT: begin
                    if (bank_q) begin
                        rdata_d = resumeCharB;
                    end else if (idxEnable) begin
                        rdata_d = idxRdata;
                        ir_d = 1'b1;
                    end else begin
                        rdata_d = lineStatus;
                    end
                end
                urb_pkg::OFS_MSTAT: begin
                    rdata_d = bank_q ? pauseCharA : modemStatus;
                end
                urb_pkg::OFS_SCRATCH: begin
                    rdata_d = bank_q ? pauseCharB : scratchPad;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_q <= urb_pkg::REG_RESET;
            bus_q <= urb_pkg::REG_RESET;
            rvalid_q <= 1'b0;
            tx_q <= 1'b0;
            rx_q <= 1'b0;
            fc_q <= 1'b0;
            sr_q <= 1'b0;
            iw_q <= 1'b0;
            ir_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            bus_q <= bus_d;
            rvalid_q <= rd;
            tx_q <= tx_d;
            rx_q <= rx_d;
            fc_q <= fc_d;
            sr_q <= sr_d;
            iw_q <= iw_d;
            ir_q <= ir_d;
        end
    end

    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
    assign txWrite = tx_q;
    assign rxRead = rx_q;
    assign fifoCtlWrite = fc_q;
    assign srcRead = sr_q;
    assign idxWrite = iw_q;
    assign idxRead = ir_q;
    assign busData = bus_q;
endmodule
`default_nettype wire

/* sim/urb_bank_monitor.sv */
// Purpose: port checks for the register window
// Assumes: bank state rebuilt here from host writes to the line format offset
// Notes: bound onto every urb_bank_top
`timescale 1ns/1ps
`default_nettype none
module urb_bank_monitor (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset
    input wire urb_pkg::urb_access_t hostAcc, // host access
    input wire logic [7:0] rxFillCount, // rx level
    input wire logic [7:0] extraControl, // extra control
    input wire logic [7:0] idxRdata, // indexed data
    input wire logic [7:0] rdata, // read data
    input wire logic rvalid, // read valid
    input wire logic txWrite, // tx load
    input wire logic fifoCtlWrite, // fifo write
    input wire logic idxRead, // indexed read
    input wire logic [7:0] busData, // write data
    input wire logic [15:0] baudDivisor, // divisor
    input wire urb_pkg::urb_frame_t frame, // framing
    input wire logic [7:0] enhFeatures, // enhanced
    input wire logic [7:0] extStatus // ext status
);
    logic latch_q;
    logic bank_q;
    logic wrLine;
    assign wrLine = hostAcc.wr && hostAcc.addr == 3'h3;
    // shadow of the bank state, since it is not visible at the ports
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            latch_q <= 1'b0;
            bank_q <= 1'b0;
        end else if (wrLine) begin
            latch_q <= hostAcc.wdata[7];
            bank_q <= hostAcc.wdata == urb_pkg::BANK_PATTERN;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_tx;
        hostAcc.wr && hostAcc.addr == 3'h0 && !latch_q
            |=> txWrite && busData == $past(hostAcc.wdata);
    endproperty
    a_tx: assert property (p_tx) else $error("tx load missing");
    property p_div;
        hostAcc.wr && hostAcc.addr == 3'h1 && latch_q && !bank_q
            |=> baudDivisor[15:8] == $past(hostAcc.wdata);
    endproperty
    a_div: assert property (p_div) else $error("divisor high wrong");
    property p_keep;
        wrLine && hostAcc.wdata == urb_pkg::BANK_PATTERN |=> frame == $past(frame);
    endproperty
    a_keep: assert property (p_keep) else $error("framing changed by bank");
    property p_frame;
        wrLine && hostAcc.wdata != urb_pkg::BANK_PATTERN
            |=> frame == urb_pkg::urb_frame_t'($past(hostAcc.wdata[6:0]));
    endproperty
    a_frame: assert property (p_frame) else $error("framing wrong");
    property p_enh;
        hostAcc.wr && hostAcc.addr == 3'h2 && bank_q
            |=> enhFeatures == $past(hostAcc.wdata) && !fifoCtlWrite;
    endproperty
    a_enh: assert property (p_enh) else $error("enhanced write wrong");
    property p_fifo;
        hostAcc.wr && hostAcc.addr == 3'h2 && !bank_q |=> fifoCtlWrite;
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo write missing");
    property p_stat;
        hostAcc.wr && hostAcc.addr == 3'h1 && extraControl[7] && !latch_q
            |=> extStatus[1:0] == $past(hostAcc.wdata[1:0]);
    endproperty
    a_stat: assert property (p_stat) else $error("ext status write wrong");
    property p_rfl;
        hostAcc.rd && hostAcc.addr == 3'h3 && extraControl[7]
            |=> rvalid && rdata == $past(rxFillCount);
    endproperty
    a_rfl: assert property (p_rfl) else $error("rx fill read wrong");
    property p_idx;
        hostAcc.rd && hostAcc.addr == 3'h5 && extraControl[6] && !bank_q
            |=> idxRead && rdata == $past(idxRdata);
    endproperty
    a_idx: assert property (p_idx) else $error("indexed read wrong");
    c_bank: cover property (wrLine && hostAcc.wdata == urb_pkg::BANK_PATTERN);
    c_div: cover property (latch_q && !bank_q && hostAcc.wr);
    c_idx: cover property (idxRead);
endmodule
bind urb_bank_top urb_bank_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .hostAcc(hostAcc),
    .rxFillCount(rxFillCount), .extraControl(extraControl), .idxRdata(idxRdata),
    .rdata(rdata), .rvalid(rvalid), .txWrite(txWrite), .fifoCtlWrite(fifoCtlWrite),
    .idxRead(idxRead), .busData(busData), .baudDivisor(baudDivisor), .frame(frame),
    .enhFeatures(enhFeatures), .extStatus(extStatus));
`default_nettype wire

/* sim/urb_host_model.sv */
// Purpose: host bus master issuing single register accesses
// Assumes: strobe launched on the falling edge, one cycle long
// Notes: idle bus carries inverted data so a stale copy never matches
`timescale 1ns/1ps
`default_nettype none
module urb_host_model (
    input wire logic sys_clk, // clock
    output var urb_pkg::urb_access_t hostAcc // host access
);
    initial hostAcc = '0;
    task automatic access(input logic [2:0] a, input logic w, input logic [7:0] d);
        @(negedge sys_clk);
        hostAcc = '{addr: a, wr: w, rd: !w, wdata: d};
        @(negedge sys_clk);
        hostAcc = '{addr: a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
endmodule
`default_nettype wire

/* sim/tb.sv */
// Purpose: directed bench for the register window and its banks
// Assumes: one access per host task, answers one edge later
// Notes: sideband status values are fixed except in t_extra, which changes them between accesses
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk;
    logic rst_n;
    urb_pkg::urb_access_t hostAcc;
    logic [7:0] rxHolding = 8'h5a, intSource = 8'hc1, lineStatus = 8'h60, modemStatus = 8'hb0;
    logic [7:0] rxFillCount = 8'h00, txFillCount = 8'h00, statusHw = 8'h00;
    logic [7:0] extraControl = 8'h00, idxRdata = 8'h00;
    logic [7:0] rdata, busData, intEnable, modemControl, scratchPad, enhFeatures, extStatus;
    logic [7:0] resumeCharA, resumeCharB, pauseCharA, pauseCharB;
    logic rvalid, txWrite, rxRead, fifoCtlWrite, srcRead, idxWrite, idxRead;
    logic [15:0] baudDivisor;
    urb_pkg::urb_frame_t frame;
    int failures = 0, nCompared = 0;
    urb_host_model host (.sys_clk(sys_clk), .hostAcc(hostAcc));
    urb_bank_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .hostAcc(hostAcc),
        .rxHolding(rxHolding), .intSource(intSource), .lineStatus(lineStatus),
        .modemStatus(modemStatus), .rxFillCount(rxFillCount), .txFillCount(txFillCount),
        .statusHw(statusHw), .extraControl(extraControl), .idxRdata(idxRdata),
        .rdata(rdata), .rvalid(rvalid), .txWrite(txWrite), .rxRead(rxRead),
        .fifoCtlWrite(fifoCtlWrite), .srcRead(srcRead), .idxWrite(idxWrite),
        .idxRead(idxRead), .busData(busData), .baudDivisor(baudDivisor), .frame(frame),
        .intEnable(intEnable), .modemControl(modemControl), .scratchPad(scratchPad),
        .enhFeatures(enhFeatures), .resumeCharA(resumeCharA), .resumeCharB(resumeCharB),
        .pauseCharA(pauseCharA), .pauseCharB(pauseCharB), .extStatus(extStatus));
    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (failures == 0 && nCompared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host.access(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
        host.access(a, 1'b0, 8'h00);
        chk("rdata", exp, rdata);
        chk("rvalid", 1'b1, rvalid);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_normal();
        wr(3'h0, 8'ha5); chk("txWrite", 1'b1, txWrite);
        chk("busData", 8'ha5, busData);
        rdc(3'h0, rxHolding); chk("rxRead", 1'b1, rxRead);
        wr(3'h2, 8'h07); chk("fifoCtlWrite", 1'b1, fifoCtlWrite);
        rdc(3'h2, intSource); chk("srcRead", 1'b1, srcRead);
        rdc(3'h5, lineStatus);
        rdc(3'h6, modemStatus);
        for (int i = 1; i < 8; i += 3) begin
            wr(3'(i), 8'(8'h30 + i));
            rdc(3'(i), 8'(8'h30 + i));
        end
    endtask
    task automatic t_latch();
        wr(3'h3, 8'h9b); chk("frame", 16'h1b, 16'(frame));
        chk("dataLength", 16'h3, 16'(frame.dataLength));
        wr(3'h0, 8'h11); chk("txWrite", 1'b0, txWrite);
        wr(3'h1, 8'h22); chk("baudDivisor", 16'h2211, baudDivisor);
        rdc(3'h1, 8'h22);
        wr(3'h3, 8'h1b); rdc(3'h0, rxHolding);
    endtask
    task automatic t_bank();
        wr(3'h3, urb_pkg::BANK_PATTERN); chk("frame", 16'h1b, 16'(frame));
        wr(3'h2, 8'h5c); chk("fifoCtlWrite", 1'b0, fifoCtlWrite);
        for (int i = 4; i < 8; i++) wr(3'(i), 8'(8'he0 + i));
        rdc(3'h2, 8'h5c);
        for (int i = 4; i < 8; i++) rdc(3'(i), 8'(8'he0 + i));
        wr(3'h3, 8'h1b);
        rdc(3'h2, intSource);
        rdc(3'h4, 8'h34);
        rdc(3'h7, 8'h37);
    endtask
    task automatic t_extra();
        extraControl = 8'h80;
        rxFillCount = 8'h2a;
        txFillCount = 8'h45;
        rdc(3'h3, 8'h2a);
        rdc(3'h4, 8'h45);
        statusHw = 8'ha4;
        wr(3'h1, 8'h5b); chk("extStatus", 8'ha7, extStatus);
        chk("intEnable", 8'h31, intEnable);
        wr(3'h3, 8'h9b);
        wr(3'h1, 8'h44); chk("baudDivisor", 16'h4411, baudDivisor);
        rdc(3'h1, 8'h44);
        wr(3'h3, 8'h1b);
        extraControl = 8'h40;
        idxRdata = 8'h9e;
        rdc(3'h5, 8'h9e); chk("idxRead", 1'b1, idxRead);
        wr(3'h5, 8'h61); chk("idxWrite", 1'b1, idxWrite);
        extraControl = 8'h00;
        rdc(3'h3, 8'h1b);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        chk("baudDivisor", 16'h0000, baudDivisor);
        t_normal();
        t_latch();
        t_bank();
        t_extra();
        end_sim();
    end
    // hang guard
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        end_sim();
    end
endmodule
`default_nettype wire
